// file: pll_ctrl_pkg.sv
`default_nettype none
package pll_ctrl_pkg;
	localparam logic [7:0] DIV_CTRL_OFFSET = 8'h16;
	localparam logic [7:0] STATUS_SEL_OFFSET = 8'h17;
	localparam logic [7:0] DIV_CTRL_RESET = 8'h00;
	localparam logic [5:0] STATUS_SEL_RESET = 6'h00;
	localparam int RESET_REF_BIT = 6;
	localparam int RESET_FB_BIT = 5;
	localparam int RESET_ALL_BIT = 4;
	localparam int B_BYPASS_BIT = 3;
	localparam int PRESCALER_LSB = 0;
	localparam int PRESCALER_W = 3;
	localparam int STATUS_SEL_LSB = 2;
	localparam int STATUS_SEL_W = 6;
	localparam int FB_DIVIDE_W = 20;

	localparam logic [2:0] PRE_FIX1 = 3'h0;
	localparam logic [2:0] PRE_FIX2 = 3'h1;
	localparam logic [2:0] PRE_DUAL2 = 3'h2;
	localparam logic [2:0] PRE_DUAL4 = 3'h3;
	localparam logic [2:0] PRE_DUAL8 = 3'h4;
	localparam logic [2:0] PRE_DUAL16 = 3'h5;
	localparam logic [2:0] PRE_DUAL32 = 3'h6;
	localparam logic [2:0] PRE_FIX3 = 3'h7;

	localparam logic [5:0] STS_GROUND = 6'h00;
	localparam logic [5:0] STS_FB_DIV = 6'h01;
	localparam logic [5:0] STS_REF_DIV = 6'h02;
	localparam logic [5:0] STS_SWALLOW = 6'h03;
	localparam logic [5:0] STS_PRESCALER = 6'h04;
	localparam logic [5:0] STS_DET_UP = 6'h05;
	localparam logic [5:0] STS_DET_DOWN = 6'h06;
	localparam logic [5:0] STS_MON_GROUND = 6'h20;
	localparam logic [5:0] STS_FIRST_REF = 6'h21;
	localparam logic [5:0] STS_SECOND_REF = 6'h22;

	localparam int SIG_FB_DIV = 0;
	localparam int SIG_REF_DIV = 1;
	localparam int SIG_SWALLOW = 2;
	localparam int SIG_PRESCALER = 3;
	localparam int SIG_DET_UP = 4;
	localparam int SIG_DET_DOWN = 5;
	localparam int SIG_FIRST_REF = 6;
	localparam int SIG_SECOND_REF = 7;
	localparam int SIG_DIFF_REF = 8;
	localparam int SIG_COUNT = 9;

	typedef logic [SIG_COUNT-1:0] probe_vec_t;

	function automatic logic is_fixed_divide(input logic [2:0] code);
		is_fixed_divide = (code == PRE_FIX1) || (code == PRE_FIX2) || (code == PRE_FIX3);
	endfunction : is_fixed_divide

	// Base modulus P; dual modulus modes may also use P+1
	function automatic logic [5:0] base_modulus(input logic [2:0] code);
		case (code)
			PRE_FIX1: base_modulus = 6'h01;
			PRE_FIX2: base_modulus = 6'h02;
			PRE_DUAL2: base_modulus = 6'h02;
			PRE_DUAL4: base_modulus = 6'h04;
			PRE_DUAL8: base_modulus = 6'h08;
			PRE_DUAL16: base_modulus = 6'h10;
			PRE_DUAL32: base_modulus = 6'h20;
			default: base_modulus = 6'h03;
		endcase
	endfunction : base_modulus
endpackage : pll_ctrl_pkg
`default_nettype wire

// file: status_sel_if.sv
`timescale 1ns/100ps
`default_nettype none
interface status_sel_if;
	import pll_ctrl_pkg::*;
	logic [5:0] sel;
	logic diff_mode;
	probe_vec_t probes;
	logic pin;
	logic dynamic;
	modport mux (input sel, input diff_mode, input probes, output pin, output dynamic);
	modport ctrl (output sel, output diff_mode, output probes, input pin, input dynamic);
endinterface : status_sel_if
`default_nettype wire

// file: status_mux.sv
`timescale 1ns/100ps
`default_nettype none
module status_mux (
	input wire logic clock_i,
	input wire logic rstn_i,
	status_sel_if.mux sel_io
);
	import pll_ctrl_pkg::*;

	// Returns {dynamic flag, routed level}
	function automatic logic [1:0] route(input logic [5:0] sel, input logic diff,
			input probe_vec_t p);
		case (sel)
			STS_FB_DIV: route = {1'b1, p[SIG_FB_DIV]};
			STS_REF_DIV: route = {1'b1, p[SIG_REF_DIV]};
			STS_SWALLOW: route = {1'b1, p[SIG_SWALLOW]};
			STS_PRESCALER: route = {1'b1, p[SIG_PRESCALER]};
			STS_DET_UP: route = {1'b1, p[SIG_DET_UP]};
			STS_DET_DOWN: route = {1'b1, p[SIG_DET_DOWN]};
			STS_FIRST_REF: route = {1'b1, diff ? p[SIG_DIFF_REF] : p[SIG_FIRST_REF]};
			STS_SECOND_REF: route = diff ? 2'b00 : {1'b1, p[SIG_SECOND_REF]};
			default: route = 2'b00;
		endcase
	endfunction : route

	wire logic [1:0] routed;
	logic pin_r;
	logic dynamic_r;

	assign routed = route(sel_io.sel, sel_io.diff_mode, sel_io.probes);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pin_r <= 1'b0;
			dynamic_r <= 1'b0;
		end else begin
			pin_r <= routed[0];
			dynamic_r <= routed[1];
		end
	end

	assign sel_io.pin = pin_r;
	assign sel_io.dynamic = dynamic_r;

	ground_sel_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_GROUND) |=> !sel_io.pin && !sel_io.dynamic)
		else $error("status pin not grounded on code 0");
	route_fb_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_FB_DIV) |=> sel_io.pin == $past(sel_io.probes[SIG_FB_DIV]))
		else $error("feedback divider not routed");
	route_down_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_DET_DOWN) |=> sel_io.pin == $past(sel_io.probes[SIG_DET_DOWN]))
		else $error("detector down pulse not routed");
	unassigned_low_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(!sel_io.sel[5] && sel_io.sel > STS_DET_DOWN) |=> !sel_io.pin && !sel_io.dynamic)
		else $error("unassigned lower code not grounded");
	monitor_ground_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_MON_GROUND) |=> !sel_io.pin)
		else $error("upper ground code not grounded");
	first_ref_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_FIRST_REF) |=> sel_io.pin == ($past(sel_io.diff_mode) ?
			$past(sel_io.probes[SIG_DIFF_REF]) : $past(sel_io.probes[SIG_FIRST_REF])))
		else $error("first reference not routed");
	second_ref_diff_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel == STS_SECOND_REF && sel_io.diff_mode) |=> !sel_io.pin)
		else $error("second reference driven in differential mode");
	dynamic_flag_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(sel_io.sel >= STS_FB_DIV && sel_io.sel <= STS_DET_DOWN) |=> sel_io.dynamic)
		else $error("divider selection not flagged dynamic");
endmodule : status_mux
`default_nettype wire

// file: pll_divider_control.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pll_divider_control (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [12:0] b_count_i,
	input wire logic [5:0] swallow_count_i,
	input wire logic differential_mode_i,
	input wire logic fb_div_delayed_i,
	input wire logic ref_div_delayed_i,
	input wire logic swallow_out_i,
	input wire logic prescaler_out_i,
	input wire logic detector_up_i,
	input wire logic detector_down_i,
	input wire logic first_reference_i,
	input wire logic second_reference_i,
	input wire logic diff_reference_i,
	output logic ref_div_reset_o,
	output logic fb_counter_reset_o,
	output logic fixed_divide_mode_o,
	output logic dual_modulus_mode_o,
	output logic [5:0] prescaler_modulus_o,
	output logic modulus_high_o,
	output logic b_bypass_active_o,
	output logic [pll_ctrl_pkg::FB_DIVIDE_W-1:0] feedback_divide_o,
	output logic status_pin_o,
	output logic status_dynamic_o
);
	import pll_ctrl_pkg::*;

	logic [7:0] div_ctrl_r;
	logic [5:0] status_sel_r;
	logic [7:0] rdata_r;
	logic [FB_DIVIDE_W-1:0] fb_divide_r;
	probe_vec_t sync1_r;
	probe_vec_t sync2_r;

	wire logic wr_div_ctrl;
	wire logic wr_status_sel;
	wire logic [7:0] read_word;
	wire logic [2:0] prescaler_code;
	wire logic fixed_mode;
	wire logic [5:0] modulus;
	wire logic [FB_DIVIDE_W-1:0] product;
	wire logic [FB_DIVIDE_W-1:0] fb_divide_nxt;
	wire probe_vec_t probes_raw;

	status_sel_if sel_bus ();

	assign wr_div_ctrl = reg_write_i && (reg_addr_i == DIV_CTRL_OFFSET);
	assign wr_status_sel = reg_write_i && (reg_addr_i == STATUS_SEL_OFFSET);
	assign read_word = (reg_addr_i == DIV_CTRL_OFFSET) ? div_ctrl_r :
		(reg_addr_i == STATUS_SEL_OFFSET) ? {status_sel_r, 2'b00} : 8'h00;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			div_ctrl_r <= DIV_CTRL_RESET;
			status_sel_r <= STATUS_SEL_RESET;
			rdata_r <= 8'h00;
		end else begin
			if (wr_div_ctrl) begin
				div_ctrl_r <= reg_wdata_i;
			end
			if (wr_status_sel) begin
				status_sel_r <= reg_wdata_i[STATUS_SEL_LSB +: STATUS_SEL_W];
			end
			rdata_r <= reg_read_i ? read_word : 8'h00;
		end
	end

	assign reg_rdata_o = rdata_r;

	// Readback and hold of both registers
	write_div_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_div_ctrl |=> div_ctrl_r == $past(reg_wdata_i))
		else $error("divider control write lost");
	write_sel_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_status_sel |=> status_sel_r == $past(reg_wdata_i[STATUS_SEL_LSB +: STATUS_SEL_W]))
		else $error("status select write lost");
	hold_div_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!wr_div_ctrl |=> $stable(div_ctrl_r))
		else $error("divider control changed without a write");
	hold_sel_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!wr_status_sel |=> $stable(status_sel_r))
		else $error("status select changed without a write");
	read_div_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(reg_read_i && reg_addr_i == DIV_CTRL_OFFSET) |=> reg_rdata_o == $past(div_ctrl_r))
		else $error("divider control readback wrong");
	read_sel_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(reg_read_i && reg_addr_i == STATUS_SEL_OFFSET) |=>
			reg_rdata_o == {$past(status_sel_r), 2'b00})
		else $error("status select readback wrong");

	// Counter resets: the combined bit overrides the separate ones
	assign ref_div_reset_o = div_ctrl_r[RESET_REF_BIT] || div_ctrl_r[RESET_ALL_BIT];
	assign fb_counter_reset_o = div_ctrl_r[RESET_FB_BIT] || div_ctrl_r[RESET_ALL_BIT];
	both_sep_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[6:4] == 3'h6) |=> ref_div_reset_o && fb_counter_reset_o)
		else $error("separate resets did not both hold");

	assign prescaler_code = div_ctrl_r[PRESCALER_LSB +: PRESCALER_W];
	assign fixed_mode = is_fixed_divide(prescaler_code);
	assign modulus = base_modulus(prescaler_code);
	assign fixed_divide_mode_o = fixed_mode;
	assign dual_modulus_mode_o = !fixed_mode;
	assign prescaler_modulus_o = modulus;
	assign modulus_high_o = !fixed_mode && (swallow_count_i != 6'h00);
	assign b_bypass_active_o = div_ctrl_r[B_BYPASS_BIT] && fixed_mode;

	// Prescaler code table spot checks
	fix1_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_FIX1) |=>
			fixed_divide_mode_o && prescaler_modulus_o == 6'h01 && !modulus_high_o)
		else $error("code 0 not fixed divide by 1");
	fix2_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_FIX2) |=>
			fixed_divide_mode_o && prescaler_modulus_o == 6'h02 && !modulus_high_o)
		else $error("code 1 not fixed divide by 2");
	dual2_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_DUAL2) |=>
			dual_modulus_mode_o && prescaler_modulus_o == 6'h02)
		else $error("code 2 not dual modulus 2");
	dual16_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_DUAL16) |=>
			dual_modulus_mode_o && prescaler_modulus_o == 6'h10)
		else $error("code 5 not dual modulus 16");
	dual32_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_DUAL32) |=>
			dual_modulus_mode_o && prescaler_modulus_o == 6'h20)
		else $error("code 6 not dual modulus 32");
	swallow_zero_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(swallow_count_i == 6'h00) |-> !modulus_high_o)
		else $error("larger modulus used with zero swallow count");
	swallow_high_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(dual_modulus_mode_o && swallow_count_i != 6'h00) |-> modulus_high_o)
		else $error("larger modulus not used with swallow count");
	bypass_fix_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[3:0] == 4'hf) |=>
			b_bypass_active_o && fixed_divide_mode_o && prescaler_modulus_o == 6'h03)
		else $error("bypass not active in fixed mode");

	// Total feedback divide: P*B (P alone when B bypass is active), plus A swallowed cycles at P+1 in dual modulus
	assign product = {14'h0, modulus} * {7'h00, b_count_i};
	assign fb_divide_nxt = b_bypass_active_o ? {14'h0, modulus} :
		fixed_mode ? product : product + {14'h0, swallow_count_i};

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			fb_divide_r <= '0;
		end else begin
			fb_divide_r <= fb_divide_nxt;
		end
	end

	assign feedback_divide_o = fb_divide_r;

	fixed_divide_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(fixed_divide_mode_o && !b_bypass_active_o) |=>
			feedback_divide_o == 20'($past(prescaler_modulus_o)) * 20'($past(b_count_i)))
		else $error("fixed divide not prescaler times B");

	// Probes run on foreign clocks; only the second stage is read
	assign probes_raw = {diff_reference_i, second_reference_i, first_reference_i,
		detector_down_i, detector_up_i, prescaler_out_i, swallow_out_i, ref_div_delayed_i,
		fb_div_delayed_i};

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= probes_raw;
			sync2_r <= sync1_r;
		end
	end

	// Each probe reaches the mux exactly two edges late
	probe_sync_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		($past(rstn_i) && $past(rstn_i, 2)) |-> sync2_r == $past(probes_raw, 2))
		else $error("probe synchroniser depth wrong");

	assign sel_bus.sel = status_sel_r;
	assign sel_bus.diff_mode = differential_mode_i;
	assign sel_bus.probes = sync2_r;

	status_mux u_status_mux (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.sel_io(sel_bus.mux)
	);

	assign status_pin_o = sel_bus.pin;
	assign status_dynamic_o = sel_bus.dynamic;

	all_reset_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[RESET_ALL_BIT]) |=> ref_div_reset_o && fb_counter_reset_o)
		else $error("reset-all did not hold all counters");
	release_all_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[6:4] == 3'h0) |=> !ref_div_reset_o && !fb_counter_reset_o)
		else $error("counters not released");
	ref_only_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[6:4] == 3'h4) |=> ref_div_reset_o && !fb_counter_reset_o)
		else $error("reference reset leaked to feedback");
	fb_only_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[6:4] == 3'h2) |=> !ref_div_reset_o && fb_counter_reset_o)
		else $error("feedback reset leaked to reference");
	bypass_div_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		b_bypass_active_o |=> feedback_divide_o == {14'h0, $past(prescaler_modulus_o)})
		else $error("bypass divide not prescaler alone");
	bypass_dual_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[3:0] == 4'hc) |=> !b_bypass_active_o && dual_modulus_mode_o)
		else $error("bypass active in dual modulus mode");
	fix3_code_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_div_ctrl && reg_wdata_i[2:0] == PRE_FIX3) |=>
			fixed_divide_mode_o && prescaler_modulus_o == 6'h03 && !modulus_high_o)
		else $error("code 7 not fixed divide by 3");
	dual_divide_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(dual_modulus_mode_o && swallow_count_i != 6'h00) |=> feedback_divide_o ==
			20'($past(prescaler_modulus_o)) * 20'($past(b_count_i)) +
			20'($past(swallow_count_i)))
		else $error("dual modulus divide wrong");
endmodule : pll_divider_control
`default_nettype wire

// file: pll_divider_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pll_divider_control_tb;
	import pll_ctrl_pkg::*;
	logic clock_i, rstn_i, we, re, diff, ref_rst, fb_rst, fixed, dual, mhigh, byp, pin, pin_kind;
	logic [7:0] addr, wdata, rdata;
	logic [12:0] bcnt;
	logic [5:0] acnt, pmod, p;
	logic [8:0] pr, oh;
	logic [FB_DIVIDE_W-1:0] fbd;
	int num_errors, cmp_count;
	// Row: write data, ref reset, fb reset, fixed mode, bypass active, base modulus
	localparam logic [17:0] DIV_ROWS [14] = '{
		{8'h00, 4'b0010, 6'h01}, {8'h01, 4'b0010, 6'h02}, {8'h02, 4'b0000, 6'h02},
		{8'h03, 4'b0000, 6'h04}, {8'h04, 4'b0000, 6'h08}, {8'h05, 4'b0000, 6'h10},
		{8'h06, 4'b0000, 6'h20}, {8'h07, 4'b0010, 6'h03}, {8'h10, 4'b1110, 6'h01},
		{8'h40, 4'b1010, 6'h01}, {8'h20, 4'b0110, 6'h01}, {8'h0F, 4'b0011, 6'h03},
		{8'h60, 4'b1110, 6'h01}, {8'h0C, 4'b0000, 6'h08}};
	// Row: differential mode, select code, routed probe index (F = ground), dynamic
	localparam logic [11:0] STS_ROWS [14] = '{
		{1'b0, 6'h00, 4'hF, 1'b0}, {1'b0, 6'h01, 4'h0, 1'b1}, {1'b0, 6'h02, 4'h1, 1'b1},
		{1'b0, 6'h03, 4'h2, 1'b1}, {1'b0, 6'h04, 4'h3, 1'b1}, {1'b0, 6'h05, 4'h4, 1'b1},
		{1'b0, 6'h06, 4'h5, 1'b1}, {1'b0, 6'h07, 4'hF, 1'b0}, {1'b0, 6'h1F, 4'hF, 1'b0},
		{1'b0, 6'h20, 4'hF, 1'b0}, {1'b0, 6'h21, 4'h6, 1'b1}, {1'b0, 6'h22, 4'h7, 1'b1},
		{1'b1, 6'h21, 4'h8, 1'b1}, {1'b1, 6'h22, 4'hF, 1'b0}};

	pll_divider_control dut_u (
		.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata), .b_count_i(bcnt),
		.swallow_count_i(acnt), .differential_mode_i(diff),
		.fb_div_delayed_i(pr[SIG_FB_DIV]), .ref_div_delayed_i(pr[SIG_REF_DIV]),
		.swallow_out_i(pr[SIG_SWALLOW]), .prescaler_out_i(pr[SIG_PRESCALER]),
		.detector_up_i(pr[SIG_DET_UP]), .detector_down_i(pr[SIG_DET_DOWN]),
		.first_reference_i(pr[SIG_FIRST_REF]), .second_reference_i(pr[SIG_SECOND_REF]),
		.diff_reference_i(pr[SIG_DIFF_REF]), .ref_div_reset_o(ref_rst),
		.fb_counter_reset_o(fb_rst), .fixed_divide_mode_o(fixed), .dual_modulus_mode_o(dual),
		.prescaler_modulus_o(pmod), .modulus_high_o(mhigh), .b_bypass_active_o(byp),
		.feedback_divide_o(fbd), .status_pin_o(pin), .status_dynamic_o(pin_kind));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clock_i);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr <= a;
		re <= 1'b1;
		@(posedge clock_i);
		re <= 1'b0;
		#1 chk("rdata", 20'(e), 20'(rdata));
		@(posedge clock_i);
		#1 chk("rdata_idle", 20'h0_0000, 20'(rdata));
	endtask : rd

	task automatic settle();
		repeat (5) @(posedge clock_i);
		#1;
	endtask : settle

	initial begin
		repeat (5000) @(posedge clock_i);
		num_errors++;
		test_done();
	end

	initial begin
		{rstn_i, we, re, diff} = 4'b0000;
		addr = 8'h00;
		wdata = 8'h00;
		bcnt = 13'h0005;
		acnt = 6'h03;
		pr = 9'h000;
		repeat (6) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(DIV_CTRL_OFFSET, 8'h00);
		rd(STATUS_SEL_OFFSET, 8'h00);
		foreach (DIV_ROWS[i]) begin
			p = DIV_ROWS[i][5:0];
			wr(DIV_CTRL_OFFSET, DIV_ROWS[i][17:10]);
			#1 chk("ref_reset", 20'(DIV_ROWS[i][9]), 20'(ref_rst));
			chk("fb_reset", 20'(DIV_ROWS[i][8]), 20'(fb_rst));
			chk("fixed", 20'(DIV_ROWS[i][7]), 20'(fixed));
			chk("dual", 20'(!DIV_ROWS[i][7]), 20'(dual));
			chk("modulus", 20'(p), 20'(pmod));
			chk("mod_high", 20'(!DIV_ROWS[i][7]), 20'(mhigh));
			chk("bypass", 20'(DIV_ROWS[i][6]), 20'(byp));
			@(posedge clock_i);
			#1 chk("fb_divide", DIV_ROWS[i][6] ? 20'(p) :
				20'(p) * 20'(bcnt) + (DIV_ROWS[i][7] ? 20'h0_0000 : 20'(acnt)), 20'(fbd));
			rd(DIV_CTRL_OFFSET, DIV_ROWS[i][17:10]);
		end
		@(posedge clock_i);
		acnt <= 6'h00;
		repeat (2) @(posedge clock_i);
		#1 chk("mod_high_a0", 20'h0_0000, 20'(mhigh));
		chk("fb_divide_a0", 20'd40, 20'(fbd));
		foreach (STS_ROWS[i]) begin
			oh = 9'h001 << STS_ROWS[i][4:1];
			wr(STATUS_SEL_OFFSET, {STS_ROWS[i][10:5], 2'b00});
			diff <= STS_ROWS[i][11];
			pr <= (STS_ROWS[i][4:1] == 4'hF) ? 9'h1FF : oh;
			settle();
			chk("status_pin", 20'(STS_ROWS[i][4:1] != 4'hF), 20'(pin));
			chk("status_kind", 20'(STS_ROWS[i][0]), 20'(pin_kind));
			@(posedge clock_i);
			pr <= ~oh;
			settle();
			chk("status_pin_low", 20'h0_0000, 20'(pin));
		end
		wr(STATUS_SEL_OFFSET, 8'hFF);
		rd(STATUS_SEL_OFFSET, 8'hFC);
		wr(8'h30, 8'hAA);
		rd(8'h30, 8'h00);
		wr(DIV_CTRL_OFFSET, 8'h10);
		#1 chk("ref_reset_pre", 20'h0_0001, 20'(ref_rst));
		chk("fb_reset_pre", 20'h0_0001, 20'(fb_rst));
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		#1 chk("ref_reset_rst", 20'h0_0000, 20'(ref_rst));
		rd(DIV_CTRL_OFFSET, 8'h00);
		test_done();
	end
endmodule : pll_divider_control_tb
`default_nettype wire
